// >>> shared/ledcmd_pkg.sv
// shared constants and types of the led driver serial command port
package ledcmd_pkg;

    // ------------------------------------------------------------
    // data widths
    // ------------------------------------------------------------
    localparam int GS_W = 16;             // grayscale word width
    localparam int CH_N = 16;             // number of output channels
    localparam int BUF_W = GS_W * CH_N;   // grayscale buffer, 256 bits
    localparam int FIFO_DEPTH = 32;       // words queued toward buffer
    localparam int FIFO_W = GS_W + 1;     // word plus global flag
    localparam int FIFO_GLB_BIT = GS_W;   // position of the global flag

    // ------------------------------------------------------------
    // edge counter and command codes (edge count halved)
    // ------------------------------------------------------------
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
    localparam logic [3:0] CMD_DLATCH = 4'h0;  // 0 or 1 edges
    localparam logic [3:0] CMD_GLATCH = 4'h1;  // 2 or 3 edges
    localparam logic [3:0] CMD_RDCFG = 4'h2;   // 4 or 5 edges
    localparam logic [3:0] CMD_DETECT = 4'h3;  // 6 or 7 edges
    localparam logic [3:0] CMD_RDERR = 4'h4;   // 8 or 9 edges
    localparam logic [3:0] CMD_WRCFG = 4'h5;   // 10 or 11 edges

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [GS_W-1:0] CFG_RST = 16'h02AD;  // config default
    localparam int CLK_NS = 10;                      // clk_sys period
    localparam int T_EDD_NS = 2000;                  // detection time
    localparam int EDD_CYC = (T_EDD_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = $clog2(EDD_CYC + 1);

    // ------------------------------------------------------------
    // interpreter states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PUSH = 2'b01,
        ST_DETECT = 2'b10
    } ledcmd_state_t;

endpackage

// >>> logic/ledcmd_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module ledcmd_fifo #(
    parameter int W = 17,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (W < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
        $error("ledcmd_fifo: depth must be a power of two above one");
    end

    logic [W-1:0] mem_r [DEPTH];   // storage
    logic [AW:0] wr_r;             // write pointer with wrap bit
    logic [AW:0] rd_r;             // read pointer with wrap bit
    logic push;
    logic pop;                     // memory into output register
    logic full;
    logic empty;                   // memory holds no word
    logic ov_r;                    // output register holds a word
    logic [W-1:0] od_r;            // output register

    // ------------------------------------------------------------
    // flags and handshakes
    // ------------------------------------------------------------
    assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign empty = (wr_r == rd_r);
    assign in_ready = ~full;
    assign out_valid = ov_r;
    assign push = in_valid & ~full;
    // refill the output register when it is free or being taken
    assign pop = (out_ready | ~ov_r) & ~empty;
    assign out_data = od_r;

    // storage write and registered read, no reset needed
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_r[AW-1:0]] <= in_data;
        end
        if (pop) begin
            od_r <= mem_r[rd_r[AW-1:0]];
        end
    end

    // pointers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
            ov_r <= 1'b0;
        end else begin
            wr_r <= wr_r + (AW+1)'(push);
            rd_r <= rd_r + (AW+1)'(pop);
            ov_r <= pop | (ov_r & ~out_ready);
        end
    end
endmodule

// >>> logic/ledcmd_pwm.sv
// pwm comparators advanced by the grayscale clock
`timescale 1ns/100ps
module ledcmd_pwm #(
    parameter int CH = 16,
    parameter int GS_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic grayscale_clock,
    input wire logic load,
    input wire logic [CH*GS_W-1:0] gs_data,
    input wire logic force_on,
    output logic [CH-1:0] chan_out
);
    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (CH < 1 || GS_W < 1) begin : g_bad
        $error("ledcmd_pwm: channel count and width must be positive");
    end

    logic grayscale_clock_s1_r;                   // first sync stage only
    logic grayscale_clock_s2_r;                   // synced grayscale clock
    logic grayscale_clock_s3_r;                   // delayed for edge detect
    logic tick;                        // one grayscale clock edge
    logic [CH*GS_W-1:0] act_r;         // latched comparator values
    logic [GS_W-1:0] cnt_r;            // pwm counter
    logic run_r;                       // armed after first edge
    logic [CH-1:0] cmp;                // compare result per channel
    logic [CH-1:0] pwm_r;              // compare result, registered
    logic [CH-1:0] out_r;              // pin drive

    // ------------------------------------------------------------
    // grayscale clock synchroniser and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        grayscale_clock_s1_r <= grayscale_clock;
        grayscale_clock_s2_r <= grayscale_clock_s1_r;
        grayscale_clock_s3_r <= grayscale_clock_s2_r;
    end
    assign tick = grayscale_clock_s2_r & ~grayscale_clock_s3_r;

    // one comparator per channel, channel 0 in the low word
    for (genvar i = 0; i < CH; i++) begin : g_cmp
        assign cmp[i] = cnt_r < act_r[i*GS_W +: GS_W];
    end

    // new data restarts the counter one grayscale edge late
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            act_r <= '0;
            cnt_r <= '0;
            run_r <= 1'b0;
            pwm_r <= '0;
        end else if (load) begin
            act_r <= gs_data;
            cnt_r <= '0;
            run_r <= 1'b0;
        end else if (tick && !run_r) begin
            run_r <= 1'b1;
        end else if (tick) begin
            cnt_r <= cnt_r + GS_W'(1);
            pwm_r <= cmp;
        end
    end

    // detection forces every channel on
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_r <= '0;
        end else begin
            out_r <= force_on ? {CH{1'b1}} : pwm_r;
        end
    end
    assign chan_out = out_r;
endmodule

// >>> logic/ledcmd_port.sv
// serial command port of a 16 channel led driver, top level
//
// Behaviour
// - each channel takes a 16-bit grayscale value
// - count strobe-high edges, act on strobe fall
// - zero or one edges: word into buffer
// - two or three edges: buffer to comparators
// - four or five edges: config into shift register
// - six or seven edges: start open detection
// - eight or nine edges: error bits readout
// - ten or eleven edges: shift register to config
// - buffer filled msb first, channel 15 first
// - first pwm output lags one grayscale clock
// - readout shifts out one bit per clock
`timescale 1ns/100ps
module ledcmd_port (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic latch_strobe,
    input wire logic grayscale_clock,
    input wire logic [15:0] open_fault,
    output logic [15:0] channel_outputs,
    output logic serial_out,
    output logic [15:0] config_word
);
    localparam int W = ledcmd_pkg::GS_W;
    localparam int CW = ledcmd_pkg::CNT_W;
    localparam int TW = ledcmd_pkg::TMR_W;
    localparam logic [TW-1:0] EDD_LOAD = TW'(ledcmd_pkg::EDD_CYC);
    localparam logic [TW-1:0] TMR_ONE = TW'(1);

    // ------------------------------------------------------------
    // link domain declarations (shift_clock)
    // ------------------------------------------------------------
    logic lrst_s1_r;             // reset sync, first stage
    logic lrst_r;                // reset in link domain
    logic [W-1:0] sr_r;          // serial shift register
    logic le_prev_r;             // strobe at previous edge
    logic [CW-1:0] cnt_r;        // edges seen with strobe high
    logic [CW-1:0] snap_cnt_r;   // count held over strobe fall
    logic [W-1:0] snap_sr_r;     // data held over strobe fall
    logic tg_s1_r;               // update toggle, first stage
    logic tg_s2_r;               // update toggle, synced
    logic tg_seen_r;             // last toggle taken
    logic [W-1:0] sh_cfg_r;      // config copy for readout
    logic [W-1:0] sh_err_r;      // error copy for readout
    logic frame_end;             // first edge after strobe fell
    logic [CW-1:0] cnt_inc;
    logic [CW-1:0] cnt_nxt;
    logic [3:0] snap_cmd;
    logic rd_cfg;
    logic rd_err;
    logic [W-1:0] sr_nxt;

    // ------------------------------------------------------------
    // system domain declarations (clk_sys)
    // ------------------------------------------------------------
    logic le_s1_r;               // strobe sync, first stage
    logic le_s2_r;               // strobe synced
    logic le_s3_r;               // strobe delayed for edge
    logic le_fall;
    logic go_r;                  // captured command ready
    logic [CW-1:0] cap_cnt_r;    // captured edge count
    logic [W-1:0] cap_sr_r;      // captured shift data
    logic [3:0] cap_cmd;
    logic [15:0] flt_s1_r;       // open fault sync, first stage
    logic [15:0] flt_s2_r;       // open fault synced
    ledcmd_pkg::ledcmd_state_t st_r;
    ledcmd_pkg::ledcmd_state_t st_nxt;
    logic [TW-1:0] tmr_r;        // detection window
    logic [W-1:0] cfg_r;         // configuration register
    logic [W-1:0] err_r;         // open circuit error bits
    logic tg_r;                  // toggles on cfg or err change
    logic [W-1:0] push_data_r;   // word waiting for the fifo
    logic push_glb_r;            // waiting word is the global one
    logic do_push;
    logic do_wrcfg;
    logic do_detect;
    logic detect_done;
    logic fifo_in_ready;
    logic fd_valid;
    logic fd_ready;
    logic [ledcmd_pkg::FIFO_W-1:0] fd_data;
    logic take;
    logic [ledcmd_pkg::BUF_W-1:0] gs_buf_r;  // 256-bit data buffer
    logic gs_load_r;             // pulse into the comparators

    // ------------------------------------------------------------
    // link reset synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge shift_clock) begin
        lrst_s1_r <= rst;
        lrst_r <= lrst_s1_r;
    end

    // ------------------------------------------------------------
    // link decoding
    // ------------------------------------------------------------
    assign frame_end = le_prev_r & ~latch_strobe;
    // saturating edge count, first high edge counts one
    assign cnt_inc = (cnt_r == ledcmd_pkg::CNT_MAX) ? cnt_r
                   : cnt_r + ledcmd_pkg::CNT_ONE;
    assign cnt_nxt = !latch_strobe ? '0
                   : le_prev_r ? cnt_inc : ledcmd_pkg::CNT_ONE;
    assign snap_cmd = snap_cnt_r[CW-1:1];
    assign rd_cfg = frame_end && (snap_cmd == ledcmd_pkg::CMD_RDCFG);
    assign rd_err = frame_end && (snap_cmd == ledcmd_pkg::CMD_RDERR);
    // read commands reload, otherwise shift serial_in in at the lsb
    assign sr_nxt = rd_cfg ? sh_cfg_r
                  : rd_err ? sh_err_r
                  : {sr_r[W-2:0], serial_in};

    // shift register, its msb is the chained serial output
    always_ff @(posedge shift_clock) begin
        if (lrst_r) begin
            sr_r <= '0;
        end else begin
            sr_r <= sr_nxt;
        end
    end
    assign serial_out = sr_r[W-1];

    // edge counter and snapshot, frozen on the edge after the fall
    always_ff @(posedge shift_clock) begin
        if (lrst_r) begin
            le_prev_r <= 1'b0;
            cnt_r <= '0;
            snap_cnt_r <= '0;
            snap_sr_r <= '0;
        end else begin
            le_prev_r <= latch_strobe;
            cnt_r <= cnt_nxt;
            if (!frame_end) begin
                snap_cnt_r <= cnt_nxt;
                snap_sr_r <= sr_nxt;
            end
        end
    end

    // readout copies: taken when the toggle from clk_sys has settled
    always_ff @(posedge shift_clock) begin
        tg_s1_r <= tg_r;
        tg_s2_r <= tg_s1_r;
    end
    always_ff @(posedge shift_clock) begin
        if (lrst_r) begin
            tg_seen_r <= 1'b0;
            sh_cfg_r <= ledcmd_pkg::CFG_RST;
            sh_err_r <= '0;
        end else if (tg_s2_r != tg_seen_r) begin
            tg_seen_r <= tg_s2_r;
            sh_cfg_r <= cfg_r;
            sh_err_r <= err_r;
        end
    end

    // ------------------------------------------------------------
    // strobe and fault synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        le_s1_r <= latch_strobe;
        le_s2_r <= le_s1_r;
        le_s3_r <= le_s2_r;
        flt_s1_r <= open_fault;
        flt_s2_r <= flt_s1_r;
    end
    assign le_fall = le_s3_r & ~le_s2_r;

    // capture the frozen snapshot once the fall is seen
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            go_r <= 1'b0;
            cap_cnt_r <= '0;
            cap_sr_r <= '0;
        end else begin
            go_r <= le_fall;
            if (le_fall) begin
                cap_cnt_r <= snap_cnt_r;
                cap_sr_r <= snap_sr_r;
            end
        end
    end

    // ------------------------------------------------------------
    // command decode and interpreter
    // ------------------------------------------------------------
    assign cap_cmd = cap_cnt_r[CW-1:1];
    assign do_push = go_r && (st_r == ledcmd_pkg::ST_IDLE)
        && ((cap_cmd == ledcmd_pkg::CMD_DLATCH)
        || (cap_cmd == ledcmd_pkg::CMD_GLATCH));
    assign do_wrcfg = go_r && (st_r == ledcmd_pkg::ST_IDLE)
        && (cap_cmd == ledcmd_pkg::CMD_WRCFG);
    assign do_detect = go_r && (st_r == ledcmd_pkg::ST_IDLE)
        && (cap_cmd == ledcmd_pkg::CMD_DETECT);
    assign detect_done = (st_r == ledcmd_pkg::ST_DETECT)
        && (tmr_r == TMR_ONE);

    // next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ledcmd_pkg::ST_IDLE: begin
                if (do_push) begin
                    st_nxt = ledcmd_pkg::ST_PUSH;
                end else if (do_detect) begin
                    st_nxt = ledcmd_pkg::ST_DETECT;
                end
            end
            ledcmd_pkg::ST_PUSH: begin
                // stalls here while the fifo is full
                if (fifo_in_ready) begin
                    st_nxt = ledcmd_pkg::ST_IDLE;
                end
            end
            ledcmd_pkg::ST_DETECT: begin
                if (detect_done) begin
                    st_nxt = ledcmd_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = ledcmd_pkg::ST_IDLE;
            end
        endcase
    end

    // state and detection timer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= ledcmd_pkg::ST_IDLE;
            tmr_r <= '0;
        end else begin
            st_r <= st_nxt;
            tmr_r <= do_detect ? EDD_LOAD
                   : (tmr_r != '0) ? tmr_r - TMR_ONE : tmr_r;
        end
    end

    // word waiting for the fifo, tagged when it is the global one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            push_data_r <= '0;
            push_glb_r <= 1'b0;
        end else if (do_push) begin
            push_data_r <= cap_sr_r;
            push_glb_r <= (cap_cmd == ledcmd_pkg::CMD_GLATCH);
        end
    end

    // configuration, error bits and the readout toggle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_r <= ledcmd_pkg::CFG_RST;
            err_r <= '0;
            tg_r <= 1'b0;
        end else begin
            if (do_wrcfg) begin
                cfg_r <= cap_sr_r;
            end
            if (detect_done) begin
                err_r <= flt_s2_r;
            end
            if (do_wrcfg || detect_done) begin
                tg_r <= ~tg_r;
            end
        end
    end
    assign config_word = cfg_r;

    // ------------------------------------------------------------
    // word queue toward the grayscale buffer
    // ------------------------------------------------------------
    ledcmd_fifo #(
        .W(ledcmd_pkg::FIFO_W),
        .DEPTH(ledcmd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(st_r == ledcmd_pkg::ST_PUSH),
        .in_ready(fifo_in_ready),
        .in_data({push_glb_r, push_data_r}),
        .out_valid(fd_valid),
        .out_ready(fd_ready),
        .out_data(fd_data)
    );

    // drain pauses for the cycle in which the buffer is handed over
    assign fd_ready = ~gs_load_r;
    assign take = fd_valid & fd_ready;

    // buffer shifts words in at the bottom, first word ends at the top
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gs_buf_r <= '0;
            gs_load_r <= 1'b0;
        end else begin
            if (take) begin
                gs_buf_r <= {gs_buf_r[ledcmd_pkg::BUF_W-W-1:0],
                             fd_data[W-1:0]};
            end
            gs_load_r <= take & fd_data[ledcmd_pkg::FIFO_GLB_BIT];
        end
    end

    // ------------------------------------------------------------
    // pwm comparators
    // ------------------------------------------------------------
    ledcmd_pwm #(
        .CH(ledcmd_pkg::CH_N),
        .GS_W(W)
    ) u_pwm (
        .clk_sys(clk_sys),
        .rst(rst),
        .grayscale_clock(grayscale_clock),
        .load(gs_load_r),
        .gs_data(gs_buf_r),
        .force_on(st_r == ledcmd_pkg::ST_DETECT),
        .chan_out(channel_outputs)
    );
endmodule

// >>> testbench/ledcmd_port_chk.sv
// assertion checker for the led driver serial command port
`timescale 1ns/100ps
module ledcmd_port_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic shift_clock,
    input wire logic latch_strobe,
    input wire logic grayscale_clock,
    input wire logic [15:0] channel_outputs,
    input wire logic serial_out,
    input wire logic [15:0] config_word
);
    // ------------------------------------------------------------
    // helper ages, saturating so idle periods stay large
    // ------------------------------------------------------------
    logic [7:0] gage_r; // cycles since grayscale clock rose
    logic [7:0] fage_r; // cycles since strobe fell
    logic [8:0] on_r;   // length of the current all-on run
    // ages restart on their event, run length on any dark channel
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gage_r <= 8'hFF;
            fage_r <= 8'hFF;
            on_r <= 9'h000;
        end else begin
            gage_r <= $rose(grayscale_clock) ? 8'h00
                : gage_r + {7'h00, gage_r != 8'hFF};
            fage_r <= $fell(latch_strobe) ? 8'h00
                : fage_r + {7'h00, fage_r != 8'hFF};
            on_r <= (&channel_outputs) ? on_r + 9'h001 : 9'h000;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // detection window seen with the grayscale clock idle
    // ------------------------------------------------------------
    sequence det_beg_s;
        $rose(&channel_outputs) && gage_r > 8'h14;
    endsequence
    sequence det_end_s;
        $fell(&channel_outputs) && gage_r > 8'h14;
    endsequence
    rst_cfg_a: assert property (
        $fell(rst) |-> config_word == ledcmd_pkg::CFG_RST)
        else $error("config word not at reset value");
    rst_out_a: assert property (
        $fell(rst) |-> channel_outputs == 16'h0000)
        else $error("channel outputs lit after reset");
    sdo_edge_a: assert property (
        $changed(serial_out) |-> $rose(shift_clock))
        else $error("serial output moved without a shift edge");
    cfg_when_a: assert property (
        $changed(config_word) |-> fage_r inside {[3:12]})
        else $error("config word changed away from a strobe fall");
    cfg_hold_a: assert property (
        latch_strobe |-> $stable(config_word))
        else $error("config word changed while strobe high");
    out_cause_a: assert property (
        $changed(channel_outputs) |-> gage_r < 8'h0C
        || (&channel_outputs) || (&$past(channel_outputs)))
        else $error("channel outputs moved without a grayscale edge");
    det_start_a: assert property (
        det_beg_s |-> fage_r inside {[3:12]})
        else $error("detection lit outputs away from a strobe fall");
    det_len_a: assert property (
        det_end_s |-> on_r inside {[199:201]})
        else $error("detection window length wrong");
endmodule

// >>> testbench/ledcmd_host.sv
// host controller model driving the serial command link
`timescale 1ns/100ps
module ledcmd_host (
    output logic shift_clock,
    output logic serial_in,
    output logic latch_strobe,
    input wire logic serial_out
);
    localparam realtime HALF = 62.5; // half of the 125 ns link period
    // link idle: clock parked low, strobe low
    initial begin
        shift_clock = 1'b0;
        serial_in = 1'b0;
        latch_strobe = 1'b0;
    end
    // bare clock edges, data line left toggling as released
    task automatic pulses(input int n);
        repeat (n) begin
            serial_in = ~serial_in;
            #HALF shift_clock = 1'b1;
            #HALF shift_clock = 1'b0;
        end
    endtask
    // one word msb first, strobe high over the last n edges
    task automatic send(input logic [15:0] w, input int n);
        int i;
        for (i = 0; i < 16; i++) begin
            serial_in = w[15-i];
            latch_strobe = (i >= 16 - n);
            #HALF shift_clock = 1'b1;
            #HALF shift_clock = 1'b0;
        end
        serial_in = ~w[0];
        latch_strobe = 1'b1;
        #HALF latch_strobe = 1'b0;
        #400; // gap covers the one period rule and the push
    endtask
    // read command then sixteen edges collecting the readout
    task automatic read(input int n, output logic [15:0] w);
        int i;
        send(16'h0000, n);
        for (i = 0; i < 16; i++) begin
            serial_in = ~serial_in;
            #HALF shift_clock = 1'b1;
            #HALF shift_clock = 1'b0;
            w[15-i] = serial_out;
        end
    endtask
endmodule

// >>> testbench/ledcmd_port_tb_top.sv
// self-checking testbench of the led driver serial command port
`timescale 1ns/100ps
module ledcmd_port_tb_top;
    logic clk_sys, rst, grayscale_clock, serial_out;
    logic shift_clock, serial_in, latch_strobe;
    logic [15:0] open_fault, channel_outputs, config_word, rd, last_exp;
    int errors, tests_run;
    ledcmd_port u_dut (.clk_sys(clk_sys), .rst(rst),
        .shift_clock(shift_clock), .serial_in(serial_in),
        .latch_strobe(latch_strobe), .grayscale_clock(grayscale_clock),
        .open_fault(open_fault), .channel_outputs(channel_outputs),
        .serial_out(serial_out), .config_word(config_word));
    ledcmd_host u_host (.shift_clock(shift_clock), .serial_in(serial_in),
        .latch_strobe(latch_strobe), .serial_out(serial_out));
    // 100 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // config read, write with both edge counts, read back
    task automatic test_cfg();
        u_host.read(4, rd);
        chk("cfg read", ledcmd_pkg::CFG_RST, rd);
        u_host.send(16'hA5C3, 10);
        chk("cfg word", 16'hA5C3, config_word);
        chk("serial out", 16'h0001, {15'h0000, serial_out});
        u_host.read(5, rd);
        chk("cfg readback", 16'hA5C3, rd);
        u_host.send(16'h3C5A, 11);
        chk("cfg word", 16'h3C5A, config_word);
        chk("serial out", 16'h0000, {15'h0000, serial_out});
        $display("test cfg done");
    endtask
    // full frame then grayscale edges, outputs against counter
    task automatic test_frame(logic [15:0] msk, logic [15:0] v0, int g);
        logic [15:0] v [16];
        logic [15:0] e;
        int j, m;
        for (j = 0; j < 16; j++) begin
            v[j] = (j == 0) ? v0 : (16'(j) & msk);
        end
        for (j = 0; j < 16; j++) begin
            u_host.send(v[15-j], (j == 15) ? g : j % 2);
        end
        cyc(20);
        for (m = 1; m <= 18; m++) begin
            grayscale_clock = 1'b1;
            cyc(13);
            grayscale_clock = 1'b0;
            cyc(13);
            for (j = 0; j < 16; j++) begin
                e[j] = (m < 2) ? last_exp[j] : (32'(m - 2) < 32'(v[j]));
            end
            chk("channel outputs", e, channel_outputs);
            last_exp = e;
        end
        $display("test frame done");
    endtask
    // detection lights all outputs, then error bits read out
    task automatic test_det(int n, int rn, logic [15:0] f);
        cyc(1);
        open_fault = f;
        u_host.send(16'h0000, n);
        chk("detect outputs", 16'hFFFF, channel_outputs);
        #2500;
        chk("after detect", last_exp, channel_outputs);
        u_host.read(rn, rd);
        chk("error bits", f, rd);
        $display("test detect done");
    endtask
    // watchdog well beyond the expected run time
    initial begin
        #400000;
        errors++;
        close_out();
    end
    initial begin
        errors = 0;
        tests_run = 0;
        last_exp = 16'h0000;
        rst = 1'b1;
        grayscale_clock = 1'b0;
        open_fault = 16'h0000;
        u_host.pulses(3);
        cyc(16);
        rst = 1'b0;
        u_host.pulses(3);
        chk("cfg reset", ledcmd_pkg::CFG_RST, config_word);
        chk("outputs reset", 16'h0000, channel_outputs);
        $display("test reset done");
        test_cfg();
        test_frame(16'hFFFF, 16'h8000, 2);
        test_frame(16'h0000, 16'h0000, 3);
        test_det(6, 8, 16'h4A21);
        test_det(7, 9, 16'hB5DE);
        close_out();
    end
endmodule
bind ledcmd_port ledcmd_port_chk u_chk (.clk_sys(clk_sys), .rst(rst),
    .shift_clock(shift_clock), .latch_strobe(latch_strobe),
    .grayscale_clock(grayscale_clock), .channel_outputs(channel_outputs),
    .serial_out(serial_out), .config_word(config_word));
